// file: rtl/gtc_timer.sv
// gated 16-bit timer/counter with apb registers and a crystal enable
// assumes apb master on sys_clk; pins and comparator are asynchronous
// Functional notes
// RULE1: crystal oscillator across the two oscillator pins runs only when enabled
// RULE2: enabled crystal oscillator keeps running during sleep
// RULE3: crystal usable only with internal or low-power crystal system clock
// RULE4: software enables crystal, waits for start-up, then starts timer
// RULE5: crystal enabled forces both pins input; data reads 0, direction 1
// RULE6: bypass select skips the system synchroniser stage
// RULE7: async external counting continues in sleep; overflow interrupt wakes
// RULE8: mode switch may lose or add one increment
// RULE9: count byte reads always return a valid value
// RULE10: software allows for overflow between two byte reads
// RULE11: software stops timer before writing the count
// RULE12: with gating on, counting only while gate is active
// RULE13: gate source is gate pin or second comparator output
// RULE14: prescaler divides by 1, 2, 4 or 8; not software visible
// RULE15: any count byte write clears the prescaler
// RULE16: counter mode increments on each external rising edge
// RULE17: after reset or re-enable a falling edge precedes first count
// RULE18: wrap from all ones sets sticky overflow flag
`default_nettype none
`include "gtc_map.svh"

module gtc_timer (
    input  wire logic        sys_clk,          // 50 mhz system clock
    input  wire logic        reset_n,          // async reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb write
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output var  logic [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb unmapped access
    input  wire logic        sleep_mode,       // processor in sleep
    input  wire logic        clk_mode_ok,      // internal or lp sys clock
    input  wire logic        pin5_in,          // count clock / osc input
    input  wire logic        pin4_in,          // osc amp output pin level
    input  wire logic        gate_input_pin,   // gate pin
    input  wire logic        second_comparator, // comparator output
    output logic             pin5_out,         // pin5 output data
    output logic             pin5_oe,          // pin5 drive enable
    output logic             pin4_out,         // pin4 output data
    output logic             pin4_oe,          // pin4 drive enable
    output logic             xtal_osc_run,     // crystal amplifier enable
    output logic             irq               // level interrupt
);
    // ------------------------------------------------------------
    // registers and wires
    // ------------------------------------------------------------
    logic [7:0]       ctrl_q;
    logic [15:0]      count_q;
    logic             ovf_flag_q;
    logic             ovf_mask_q;
    logic [1:0]       dir_q;
    logic [1:0]       data_q;
    logic [2:0]       ps_q;
    logic [2:0]       ps_last;
    logic [1:0]       instr_q;
    logic             ext_stage_q;
    logic             ext_prev_q;
    gtc_pkg::gtc_arm_t arm_q;
    logic [3:0]       sync_lvl;
    logic             run;
    logic             ext_sel;
    logic             sync_byp;
    logic             osc_en;
    logic             ext_lvl;
    logic             ext_rise;
    logic             gate_lvl;
    logic             gate_ok;
    logic             src_tick;
    logic             pre_tick;
    logic             inc;
    logic             ovf_evt;
    logic             wr_en;
    logic             rd_setup;
    logic             wr_lo;
    logic             wr_hi;
    logic             mapped;

    assign run      = ctrl_q[`GTC_CTRL_RUN];
    assign ext_sel  = ctrl_q[`GTC_CTRL_EXT_SEL];
    assign sync_byp = ctrl_q[`GTC_CTRL_SYNC_BYP];
    assign osc_en   = ctrl_q[`GTC_CTRL_OSC_EN];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    // zero-wait slave; unmapped offsets flag an error
    assign mapped   = (paddr == `GTC_OFF_CTRL) || (paddr == `GTC_OFF_CNT_LO)
                   || (paddr == `GTC_OFF_CNT_HI) || (paddr == `GTC_OFF_STATUS)
                   || (paddr == `GTC_OFF_MASK) || (paddr == `GTC_OFF_PIN_DIR)
                   || (paddr == `GTC_OFF_PIN_DATA);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_lo    = wr_en && (paddr == `GTC_OFF_CNT_LO);
    assign wr_hi    = wr_en && (paddr == `GTC_OFF_CNT_HI);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    gtc_sync #(
        .WIDTH    (4)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .async_in ({second_comparator, gate_input_pin, pin4_in, pin5_in}),
        .sync_out (sync_lvl)
    );

    // ------------------------------------------------------------
    // oscillator and shared pins
    // ------------------------------------------------------------
    // RULE1 RULE3 crystal run control
    // RULE2 sleep does not stop it
    assign xtal_osc_run = osc_en && clk_mode_ok;
    // RULE5 pins forced to input
    assign pin4_oe  = !osc_en && !dir_q[0];
    assign pin5_oe  = !osc_en && !dir_q[1];
    assign pin4_out = data_q[0];
    assign pin5_out = data_q[1];

    // ------------------------------------------------------------
    // count sources
    // ------------------------------------------------------------
    // RULE6 RULE8 extra phase stage unless bypassed
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ext_stage_q <= 1'b0;
        else if (!sleep_mode)
            ext_stage_q <= sync_lvl[0];
    end

    assign ext_lvl = sync_byp ? sync_lvl[0] : ext_stage_q;

    // previous external level for edge detect
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ext_prev_q <= 1'b0;
        else
            ext_prev_q <= ext_lvl;
    end

    // RULE16 rising edge of count pin
    assign ext_rise = ext_lvl && !ext_prev_q;

    // RULE17 arm on a low level after enable
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            arm_q <= gtc_pkg::GTC_DISARMED;
        else if (!run)
            arm_q <= gtc_pkg::GTC_DISARMED;
        else if (!ext_lvl)
            arm_q <= gtc_pkg::GTC_ARMED;
    end

    // instruction clock divider, stops in sleep
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            instr_q <= 2'h0;
        else if (!sleep_mode)
            instr_q <= instr_q + 2'h1;
    end

    // RULE7 async external path ignores sleep
    always_comb
    begin
        if (ext_sel)
            src_tick = ext_rise && (arm_q == gtc_pkg::GTC_ARMED)
                    && (sync_byp || !sleep_mode);
        else
            src_tick = (instr_q == `GTC_INSTR_LAST) && !sleep_mode;
    end

    // ------------------------------------------------------------
    // gate
    // ------------------------------------------------------------
    // RULE13 gate source select
    assign gate_lvl = ctrl_q[`GTC_CTRL_GATE_SRC] ? sync_lvl[3] : sync_lvl[2];
    // RULE12 count only while gate active
    assign gate_ok  = !ctrl_q[`GTC_CTRL_GATE_EN] || gate_lvl;
    assign pre_tick = run && gate_ok && src_tick;

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    // RULE14 terminal value per division
    always_comb
    begin
        case (ctrl_q[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO])
            2'h0:    ps_last = 3'h0;
            2'h1:    ps_last = 3'h1;
            2'h2:    ps_last = 3'h3;
            default: ps_last = 3'h7;
        endcase
    end

    // RULE15 count writes clear the prescaler
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ps_q <= 3'h0;
        else if (wr_lo || wr_hi)
            ps_q <= 3'h0;
        else if (pre_tick)
            ps_q <= (ps_q == ps_last) ? 3'h0 : ps_q + 3'h1;
    end

    assign inc     = pre_tick && (ps_q == ps_last);
    assign ovf_evt = inc && (count_q == `GTC_CNT_MAX);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // byte writes win over a coincident increment
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= 16'h0000;
        else if (wr_lo)
            count_q[7:0] <= pwdata[7:0];
        else if (wr_hi)
            count_q[15:8] <= pwdata[7:0];
        else if (inc)
            count_q <= count_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // control, mask and pin registers
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q     <= `GTC_CTRL_RST;
            ovf_mask_q <= 1'b0;
            dir_q      <= `GTC_DIR_RST;
            data_q     <= `GTC_DATA_RST;
        end
        else if (wr_en)
        begin
            if (paddr == `GTC_OFF_CTRL)
                ctrl_q <= pwdata[7:0];
            else if (paddr == `GTC_OFF_MASK)
                ovf_mask_q <= pwdata[`GTC_STAT_OVF];
            else if (paddr == `GTC_OFF_PIN_DIR)
                dir_q <= pwdata[`GTC_PIN5:`GTC_PIN4];
            else if (paddr == `GTC_OFF_PIN_DATA)
                data_q <= pwdata[`GTC_PIN5:`GTC_PIN4];
        end
    end

    // RULE18 sticky overflow, set beats clear
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ovf_flag_q <= 1'b0;
        else if (ovf_evt)
            ovf_flag_q <= 1'b1;
        else if (wr_en && (paddr == `GTC_OFF_STATUS)
                 && pwdata[`GTC_STAT_OVF])
            ovf_flag_q <= 1'b0;
    end

    // RULE7 level interrupt wakes the core
    assign irq = ovf_flag_q && ovf_mask_q;

    // RULE9 read data latched in setup phase
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= 32'h0000_0000;
        else if (rd_setup)
        begin
            prdata <= 32'h0000_0000;
            if (paddr == `GTC_OFF_CTRL)
                prdata[7:0] <= ctrl_q;
            else if (paddr == `GTC_OFF_CNT_LO)
                prdata[7:0] <= count_q[7:0];
            else if (paddr == `GTC_OFF_CNT_HI)
                prdata[7:0] <= count_q[15:8];
            else if (paddr == `GTC_OFF_STATUS)
                prdata[`GTC_STAT_OVF] <= ovf_flag_q;
            else if (paddr == `GTC_OFF_MASK)
                prdata[`GTC_STAT_OVF] <= ovf_mask_q;
            // RULE5 forced pins read as inputs
            else if (paddr == `GTC_OFF_PIN_DIR)
                prdata[`GTC_PIN5:`GTC_PIN4] <= osc_en ? `GTC_DIR_RST : dir_q;
            // bit 5 is pin5 (sync_lvl[0]), bit 4 is pin4 (sync_lvl[1])
            else if (paddr == `GTC_OFF_PIN_DATA)
                prdata[`GTC_PIN5:`GTC_PIN4] <= osc_en ? `GTC_DATA_RST
                                             : {sync_lvl[0], sync_lvl[1]};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    property p_ovf_set;
        ovf_evt |=> ovf_flag_q && (count_q == 16'h0000);
    endproperty
    a_ovf_set: assert property (p_ovf_set) // RULE18
        else $error("overflow did not set flag");

    property p_osc_sleep;
        osc_en && clk_mode_ok && sleep_mode |-> xtal_osc_run;
    endproperty
    a_osc_sleep: assert property (p_osc_sleep) // RULE2
        else $error("crystal stopped in sleep");

    property p_pins_in;
        osc_en |-> !pin4_oe && !pin5_oe;
    endproperty
    a_pins_in: assert property (p_pins_in) // RULE5
        else $error("shared pin driven with crystal on");

    property p_ps_clr;
        wr_lo || wr_hi |=> ps_q == 3'h0;
    endproperty
    a_ps_clr: assert property (p_ps_clr) // RULE15
        else $error("prescaler not cleared by count write");

    property p_gate_hold;
        run && ctrl_q[`GTC_CTRL_GATE_EN] && !gate_lvl && !wr_lo && !wr_hi
            |=> $stable(count_q);
    endproperty
    a_gate_hold: assert property (p_gate_hold) // RULE12
        else $error("count moved with gate closed");

    property p_disarm;
        !run |=> arm_q == gtc_pkg::GTC_DISARMED;
    endproperty
    a_disarm: assert property (p_disarm) // RULE17
        else $error("armed while stopped");

    property p_async_count;
        ext_sel && sync_byp && sleep_mode && inc && !wr_lo && !wr_hi
            |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_async_count: assert property (p_async_count) // RULE7
        else $error("async count lost in sleep");

    property p_div8;
        ctrl_q[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO] == 2'h3 && ps_q != 3'h7
            && !wr_lo && !wr_hi |=> $stable(count_q);
    endproperty
    a_div8: assert property (p_div8) // RULE14
        else $error("divide by 8 counted early");

    property p_irq;
        ovf_evt && ovf_mask_q
            && !(wr_en && (paddr == `GTC_OFF_MASK)) |=> irq;
    endproperty
    a_irq: assert property (p_irq) // RULE7
        else $error("interrupt not raised");

    c_ovf:   cover property (ovf_evt);
    c_gated: cover property (run && !gate_ok && src_tick);
    c_async: cover property (sleep_mode && sync_byp && inc);

endmodule : gtc_timer

`default_nettype wire

// file: rtl/gtc_map.svh
// register offsets, field positions and reset values of the gated timer
// assumes an 8-bit apb byte address and 32-bit data words
`ifndef GTC_MAP_SVH
`define GTC_MAP_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define GTC_OFF_CTRL     8'h00
`define GTC_OFF_CNT_LO   8'h04
`define GTC_OFF_CNT_HI   8'h08
`define GTC_OFF_STATUS   8'h0c
`define GTC_OFF_MASK     8'h10
`define GTC_OFF_PIN_DIR  8'h14
`define GTC_OFF_PIN_DATA 8'h18

// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define GTC_CTRL_RUN      0
`define GTC_CTRL_EXT_SEL  1
`define GTC_CTRL_SYNC_BYP 2
`define GTC_CTRL_OSC_EN   3
`define GTC_CTRL_PS_LO    4
`define GTC_CTRL_PS_HI    5
`define GTC_CTRL_GATE_EN  6
`define GTC_CTRL_GATE_SRC 7
`define GTC_CTRL_RST      8'h00

// ------------------------------------------------------------
// status, pin and timing constants
// ------------------------------------------------------------
`define GTC_STAT_OVF      0
`define GTC_PIN4          4
`define GTC_PIN5          5
`define GTC_DIR_RST       2'h3
`define GTC_DATA_RST      2'h0
`define GTC_CNT_MAX       16'hffff
`define GTC_INSTR_LAST    2'h3
`define GTC_XTAL_FREQ_HZ  32768

`endif

// file: rtl/gtc_pkg.sv
// types shared by the gated timer files
// assumes nothing beyond a sv compiler
`default_nettype none

package gtc_pkg;
    // arming state for the external edge counter
    typedef enum logic [0:0]
    {
        GTC_DISARMED = 1'b0,
        GTC_ARMED    = 1'b1
    } gtc_arm_t;
endpackage : gtc_pkg

`default_nettype wire

// file: rtl/gtc_sync.sv
// two-flop synchroniser, one per bit of the bus
// assumes inputs come from pins or another clock domain
`default_nettype none

module gtc_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             sys_clk,  // system clock
    input  wire logic             reset_n,  // async reset, active low
    input  wire logic [WIDTH-1:0] async_in, // raw inputs
    output var  logic [WIDTH-1:0] sync_out  // synchronised levels
);
    // ------------------------------------------------------------
    // per-bit flop pairs
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_q;
            // first flop only feeds the second
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    meta_q      <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    meta_q      <= async_in[i];
                    sync_out[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule : gtc_sync

`default_nettype wire

// file: testbench/gtc_src_model.sv
// external count clock source standing at the shared oscillator pins
// assumes the bench calls its tasks from one clocked sequence
`default_nettype none

module gtc_src_model (
    input  wire logic sys_clk, // system clock, paces the edges only
    output var  logic src5,    // count clock level offered to pin5
    output var  logic src4     // level offered to pin4
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------
    // idle levels
    // ----------------------------------------------------------
    // count clock rests low, second pin rests high
    initial
    begin
        src5 = 1'b0;
        src4 = 1'b1;
    end

    // ----------------------------------------------------------
    // edge generation
    // ----------------------------------------------------------
    // n full periods; hold of 3 or more outlasts the synchroniser
    task automatic pulse(input int n, input int hold);
        repeat (n)
        begin
            @(posedge sys_clk) src5 <= 1'b1;
            repeat (hold) @(posedge sys_clk);
            src5 <= 1'b0;
            repeat (hold) @(posedge sys_clk);
        end
    endtask : pulse

    // parks the count clock at one level
    task automatic level(input logic v);
        @(posedge sys_clk) src5 <= v;
        repeat (5) @(posedge sys_clk);
    endtask : level
endmodule : gtc_src_model

`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the gated timer over apb
// assumes the timer, its map header and the source model are compiled
`default_nettype none
`include "gtc_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic        sleep_mode, clk_mode_ok, gate_input_pin, second_comparator;
    logic        pin5_in, pin4_in, pin5_out, pin5_oe, pin4_out, pin4_oe;
    logic        xtal_osc_run, irq, err, src5, src4;
    logic [15:0] c;
    int          fails, n_tests, seed, exp_cnt, n;

    gtc_timer DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .clk_mode_ok(clk_mode_ok),
        .pin5_in(pin5_in), .pin4_in(pin4_in),
        .gate_input_pin(gate_input_pin),
        .second_comparator(second_comparator), .pin5_out(pin5_out),
        .pin5_oe(pin5_oe), .pin4_out(pin4_out), .pin4_oe(pin4_oe),
        .xtal_osc_run(xtal_osc_run), .irq(irq));
    gtc_src_model src (.sys_clk(sys_clk), .src5(src5), .src4(src4));

    // pin level: the timer wins while it drives
    assign pin5_in = pin5_oe ? pin5_out : src5;
    assign pin4_in = pin4_oe ? pin4_out : src4;

    // 50 mhz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("counts: compares=%0d mismatches=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        int i;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk) penable <= 1'b1;
        i = 0;
        @(posedge sys_clk);
        while (pready !== 1'b1 && i < 20)
        begin
            i++;
            @(posedge sys_clk);
        end
        if (i == 20)
        begin
            fails++;
            test_done();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic settle;
        @(negedge sys_clk);
    endtask : settle

    task automatic cnt_wr(input logic [15:0] v);
        apb(1'b1, `GTC_OFF_CNT_LO, {24'h0, v[7:0]});
        apb(1'b1, `GTC_OFF_CNT_HI, {24'h0, v[15:8]});
    endtask : cnt_wr

    // byte pair read only while the count is quiet
    task automatic cnt_rd;
        apb(1'b0, `GTC_OFF_CNT_LO, 32'h0);
        c[7:0] = rd[7:0];
        apb(1'b0, `GTC_OFF_CNT_HI, 32'h0);
        c[15:8] = rd[7:0];
    endtask : cnt_rd

    // stop, load count, then start with the given control value
    task automatic restart(input logic [15:0] v, input logic [31:0] ctl);
        apb(1'b1, `GTC_OFF_CTRL, 32'h0);
        cnt_wr(v);
        apb(1'b1, `GTC_OFF_CTRL, ctl);
    endtask : restart

    // hang guard
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        fails++;
        test_done();
    end

    // ----------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------
    initial
    begin
        seed = 23;
        fails = 0;
        n_tests = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sleep_mode = 1'b0;
        clk_mode_ok = 1'b1;
        gate_input_pin = 1'b0;
        second_comparator = 1'b0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        // reset values and the unmapped hole
        apb(1'b0, `GTC_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `GTC_OFF_PIN_DIR, 32'h0);
        chk(rd, 32'h30);
        apb(1'b0, `GTC_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h1c, 32'hff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        chk({30'h0, pin5_oe, pin4_oe}, 32'h0);
        $display("test reset done");
        // pins as outputs, then the crystal takes them
        d = $random(seed) & 32'h30;
        apb(1'b1, `GTC_OFF_PIN_DIR, 32'h0);
        apb(1'b1, `GTC_OFF_PIN_DATA, d);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, `GTC_OFF_PIN_DATA, 32'h0);
        chk(rd & 32'h30, d);
        chk({30'h0, pin5_oe, pin4_oe}, 32'h3);
        apb(1'b1, `GTC_OFF_CTRL, 32'h08);
        repeat (8) @(posedge sys_clk);
        settle();
        chk({31'h0, xtal_osc_run}, 32'h1);
        chk({30'h0, pin5_oe, pin4_oe}, 32'h0);
        apb(1'b0, `GTC_OFF_PIN_DIR, 32'h0);
        chk(rd & 32'h30, 32'h30);
        apb(1'b0, `GTC_OFF_PIN_DATA, 32'h0);
        chk(rd & 32'h30, 32'h0);
        sleep_mode <= 1'b1;
        settle();
        chk({31'h0, xtal_osc_run}, 32'h1);
        @(posedge sys_clk);
        clk_mode_ok <= 1'b0;
        settle();
        chk({31'h0, xtal_osc_run}, 32'h0);
        @(posedge sys_clk);
        clk_mode_ok <= 1'b1;
        sleep_mode <= 1'b0;
        apb(1'b1, `GTC_OFF_CTRL, 32'h0);
        settle();
        chk({31'h0, xtal_osc_run}, 32'h0);
        apb(1'b1, `GTC_OFF_PIN_DIR, 32'h30);
        $display("test crystal done");
        // random load and read back while stopped
        d = $random(seed);
        cnt_wr(d[15:0]);
        cnt_rd();
        chk({16'h0, c}, {16'h0, d[15:0]});
        src.level(1'b1);
        restart(16'h0, 32'h03);
        repeat (10) @(posedge sys_clk);
        cnt_rd();
        chk({16'h0, c}, 32'h0);
        src.level(1'b0);
        src.pulse(1, 3);
        exp_cnt = 1;
        n = 1 + ($random(seed) & 15);
        src.pulse(n, 7);
        exp_cnt += n;
        cnt_rd();
        chk({16'h0, c}, exp_cnt);
        $display("test external edges done");
        for (int ps = 0; ps < 4; ps++)
        begin
            src.pulse(3, 3);
            restart(16'h0, 32'h03 | (ps << 4));
            // one pulse short: a stale prescaler would reach count 8
            src.pulse((8 << ps) - 1, 3);
            cnt_rd();
            chk({16'h0, c}, 32'h7);
        end
        $display("test prescaler done");
        // gate closed, then open, for each source
        for (int gs = 0; gs < 2; gs++)
        begin
            gate_input_pin <= gs[0];
            second_comparator <= ~gs[0];
            restart(16'h0, 32'h43 | (gs << 7));
            src.pulse(2, 3);
            cnt_rd();
            chk({16'h0, c}, 32'h0);
            gate_input_pin <= ~gs[0];
            second_comparator <= gs[0];
            src.pulse(3, 3);
            cnt_rd();
            chk({16'h0, c}, 32'h3);
        end
        $display("test gate done");
        sleep_mode <= 1'b1;
        restart(16'h0, 32'h03);
        src.pulse(2, 3);
        cnt_rd();
        chk({16'h0, c}, 32'h0);
        apb(1'b1, `GTC_OFF_CTRL, 32'h07);
        src.pulse(2, 3);
        cnt_rd();
        chk({16'h0, c}, 32'h2);
        apb(1'b1, `GTC_OFF_MASK, 32'h1);
        restart(16'hffff, 32'h07);
        src.pulse(1, 3);
        cnt_rd();
        chk({16'h0, c}, 32'h0);
        apb(1'b0, `GTC_OFF_STATUS, 32'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq}, 32'h1);
        sleep_mode <= 1'b0;
        apb(1'b1, `GTC_OFF_MASK, 32'h0);
        settle();
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `GTC_OFF_MASK, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, `GTC_OFF_STATUS, 32'h1);
        settle();
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, `GTC_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("test sleep and overflow done");
        // internal source: sys_clk over four, then frozen when stopped
        restart(16'h0, 32'h01);
        repeat (80) @(posedge sys_clk);
        apb(1'b1, `GTC_OFF_CTRL, 32'h0);
        cnt_rd();
        chk({31'h0, (c >= 16'd18 && c <= 16'd26)}, 32'h1);
        d = {16'h0, c};
        repeat (20) @(posedge sys_clk);
        cnt_rd();
        chk({16'h0, c}, d);
        $display("test internal clock done");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
